// [verilog/smf_regmap.sv]
// register map of the stack monitor: flags, temperatures, check byte, config byte zero
`timescale 1ns/100ps
`include "smf_consts.svh"
//
// Behaviour
// - flag bytes alternate under then over, cells 1-12
// - ten-cell mode zeroes cell 11 and 12 flags
// - external temperatures packed little-endian across bytes
// - internal temp, shutdown bit, revision in bytes 3-4
// - read-only check byte over returned data
// - duty code 0 is standby, comparator off
// - codes 2-7 select comparator period and reference, code 1 keeps reference only
// - measure-mode pin low forces duty code 5
// - poll style bit 0 toggle, 1 level
// - pin one written 0 pulls down, default off
// - pin one reads its sampled level
// - pin two written 0 pulls down, default off
// - pin two reads its sampled level
// - thresholds are code times 16 times 1.5 mV
// - shutdown bit sticky until temperature group read
module smf_regmap #(
  parameter int unsigned MS_CYCLES = `SMF_MS_CYCLES,
  parameter logic [2:0] REV_CODE = 3'h1 // arbitrary value
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register access
  input wire logic [3:0] reg_idx,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic temp_group_done,
  output logic [7:0] reg_rdata,
  output logic [7:0] packet_check_byte,
  // measurement inputs
  input wire smf_pkg::smf_cell_t [11:0] cell_volts,
  input wire smf_pkg::smf_temp_t temps,
  input wire logic [7:0] under_threshold,
  input wire logic [7:0] over_threshold,
  input wire logic [11:0] cell_mask,
  input wire logic shutdown_event,
  // pins
  input wire logic measure_mode_pin_n,
  input wire logic general_pin_one_in,
  input wire logic general_pin_two_in,
  output logic general_pin_one_pd,
  output logic general_pin_two_pd,
  // mode outputs
  output smf_pkg::smf_cdc_t comparator_duty_code,
  output smf_pkg::smf_power_t power_state,
  output logic ten_cell_select,
  output logic poll_style_select,
  output logic compare_tick
);
  import smf_pkg::*;

  // ==========================================================
  // pin synchronisers
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= 3'h7;
      pin_sync <= 3'h7;
    end else begin
      pin_meta <= {measure_mode_pin_n, general_pin_two_in, general_pin_one_in};
      pin_sync <= pin_meta;
    end
  end
  wire mm_low = !pin_sync[2];
  wire pin_one_level = pin_sync[0];
  wire pin_two_level = pin_sync[1];

  // ==========================================================
  // config byte zero
  logic [2:0] cdc_written;
  logic pin_one_ctl;
  logic pin_two_ctl;
  wire cfg_wr = reg_wr && (reg_idx == `SMF_IDX_CFG0);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cdc_written <= `SMF_CDC_RESET;
      ten_cell_select <= `SMF_TEN_CELL_RESET;
      poll_style_select <= `SMF_POLL_RESET;
      pin_one_ctl <= `SMF_PIN_RESET;
      pin_two_ctl <= `SMF_PIN_RESET;
    end else if (cfg_wr) begin
      cdc_written <= reg_wdata[`SMF_CDC_MSB:`SMF_CDC_LSB];
      ten_cell_select <= reg_wdata[`SMF_TEN_CELL_BIT];
      poll_style_select <= reg_wdata[`SMF_POLL_BIT];
      pin_one_ctl <= reg_wdata[`SMF_PIN_ONE_BIT];
      pin_two_ctl <= reg_wdata[`SMF_PIN_TWO_BIT];
    end
  end
  assign general_pin_one_pd = !pin_one_ctl;
  assign general_pin_two_pd = !pin_two_ctl;

  wire [2:0] cdc_eff = mm_low ? `SMF_CDC_FORCED : cdc_written;
  assign comparator_duty_code = smf_cdc_t'(cdc_eff);

  // ==========================================================
  // comparator period, in milliseconds per duty code
  function automatic logic [11:0] period_ms(input logic [2:0] code);
    case (code)
      3'h2: period_ms = 12'd13;
      3'h3, 3'h5: period_ms = 12'd130;
      3'h4, 3'h6: period_ms = 12'd500;
      3'h7: period_ms = 12'd2000;
      default: period_ms = 12'h000;
    endcase
  endfunction : period_ms
  wire cmp_on = (cdc_eff > 3'h1);
  assign power_state.comparator_on = cmp_on;
  assign power_state.vref_on = (cdc_eff >= 3'h1) && (cdc_eff <= 3'h4);

  logic [31:0] ms_div;
  logic [11:0] ms_count;
  wire ms_tick = (ms_div == MS_CYCLES - 1);
  wire period_end = ms_tick && (ms_count >= period_ms(cdc_eff) - 12'h001);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ms_div <= 32'h0;
      ms_count <= 12'h000;
    end else if (!cmp_on) begin
      ms_div <= 32'h0;
      ms_count <= 12'h000;
    end else begin
      ms_div <= ms_tick ? 32'h0 : ms_div + 32'h1;
      if (ms_tick) begin
        ms_count <= period_end ? 12'h000 : ms_count + 12'h001;
      end
    end
  end
  assign compare_tick = cmp_on && period_end;

  // ==========================================================
  // limit flags: threshold is code * 16 counts of 1.5 mV
  logic [23:0] flags;
  wire [11:0] uv_lim = {under_threshold, 4'h0};
  wire [11:0] ov_lim = {over_threshold, 4'h0};
  logic [23:0] next_flags;
  generate
    for (genvar c = 0; c < 12; c++) begin : g_cell
      wire live = !(ten_cell_select && c >= 10);
      assign next_flags[2*c] = cell_mask[c] ? flags[2*c] :
        live && (cell_volts[c].volts < uv_lim);
      assign next_flags[2*c+1] = cell_mask[c] ? flags[2*c+1] :
        live && (cell_volts[c].volts > ov_lim);
    end
  endgenerate
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags <= 24'h0;
    end else if (compare_tick) begin
      flags <= next_flags;
    end
  end
  wire [23:0] flags_view = ten_cell_select ? {4'h0, flags[19:0]} : flags;

  // ==========================================================
  // thermal shutdown: set wins over read clear
  logic thermal_shutdown_seen;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      thermal_shutdown_seen <= 1'h0;
    end else if (shutdown_event) begin
      thermal_shutdown_seen <= 1'h1;
    end else if (temp_group_done) begin
      thermal_shutdown_seen <= 1'h0;
    end
  end

  // ==========================================================
  // read view
  wire [7:0] config_byte_zero = {1'h0, pin_two_level, pin_one_level, poll_style_select,
    ten_cell_select, cdc_eff};
  wire [7:0] temp_byte_1 = {temps.ext_two[3:0], temps.ext_one[11:8]};
  wire [7:0] temperature_status_rev = {REV_CODE, thermal_shutdown_seen,
    temps.internal[11:8]};
  wire [7:0] sel_byte =
    (reg_idx == `SMF_IDX_FLAGS_0) ? flags_view[7:0] :
    (reg_idx == `SMF_IDX_FLAGS_1) ? flags_view[15:8] :
    (reg_idx == `SMF_IDX_FLAGS_2) ? flags_view[23:16] :
    (reg_idx == `SMF_IDX_TEMP_0) ? temps.ext_one[7:0] :
    (reg_idx == `SMF_IDX_TEMP_1) ? temp_byte_1 :
    (reg_idx == `SMF_IDX_TEMP_2) ? temps.ext_two[11:4] :
    (reg_idx == `SMF_IDX_TEMP_3) ? temps.internal[7:0] :
    (reg_idx == `SMF_IDX_TEMP_4) ? temperature_status_rev :
    (reg_idx == `SMF_IDX_CHECK) ? packet_check_byte :
    (reg_idx == `SMF_IDX_CFG0) ? config_byte_zero : 8'h00;

  // check byte: crc-8, polynomial x^8+x^2+x+1, restarts after it is read
  function automatic logic [7:0] crc8(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] c;
    c = crc;
    for (int i = 7; i >= 0; i--) begin
      c = (c[7] ^ data[i]) ? ((c << 1) ^ 8'h07) : (c << 1);
    end
    return c;
  endfunction : crc8
  wire check_rd = reg_rd && (reg_idx == `SMF_IDX_CHECK);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
      packet_check_byte <= 8'h41;
    end else if (reg_rd) begin
      reg_rdata <= sel_byte;
      packet_check_byte <= check_rd ? 8'h41 : crc8(packet_check_byte, sel_byte);
    end
  end

  // ==========================================================
  // assertions
  a_forced_cdc: assert property (@(posedge clk) disable iff (!rst_n)
    mm_low |-> comparator_duty_code == smf_cdc_130_pd)
    else $error("duty code not forced while measure pin low");
  a_ten_cell_zero: assert property (@(posedge clk) disable iff (!rst_n)
    ten_cell_select |-> flags_view[23:20] == 4'h0)
    else $error("cell 11/12 flags visible in ten-cell mode");
  a_standby_off: assert property (@(posedge clk) disable iff (!rst_n)
    (cdc_eff == 3'h0) |-> !power_state.comparator_on && !power_state.vref_on)
    else $error("standby leaves comparator or reference on");
  a_ref_down: assert property (@(posedge clk) disable iff (!rst_n)
    (cdc_eff >= 3'h5) |-> power_state.comparator_on && !power_state.vref_on)
    else $error("reference not powered down for codes 5-7");
  a_shutdown_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    shutdown_event |=> thermal_shutdown_seen)
    else $error("shutdown event lost");
  a_shutdown_clear: assert property (@(posedge clk) disable iff (!rst_n)
    temp_group_done && !shutdown_event |=> !thermal_shutdown_seen)
    else $error("shutdown bit not cleared by group read");
  a_pin_one_pd: assert property (@(posedge clk) disable iff (!rst_n)
    cfg_wr && !reg_wdata[`SMF_PIN_ONE_BIT] |=> general_pin_one_pd)
    else $error("pin one pull-down not on after write of 0");
  a_pin_two_pd: assert property (@(posedge clk) disable iff (!rst_n)
    cfg_wr && reg_wdata[`SMF_PIN_TWO_BIT] |=> !general_pin_two_pd)
    else $error("pin two pull-down not off after write of 1");
  a_flag_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !compare_tick |=> $stable(flags))
    else $error("flags changed outside evaluation");
  a_read_temp4: assert property (@(posedge clk) disable iff (!rst_n)
    reg_rd && reg_idx == `SMF_IDX_TEMP_4 |=> reg_rdata[7:5] == REV_CODE)
    else $error("revision code misplaced");
  c_compare: cover property (@(posedge clk) disable iff (!rst_n) compare_tick);
  c_shutdown: cover property (@(posedge clk) disable iff (!rst_n)
    thermal_shutdown_seen ##1 temp_group_done);
  c_ten_cell: cover property (@(posedge clk) disable iff (!rst_n)
    ten_cell_select && reg_rd && reg_idx == `SMF_IDX_FLAGS_2);
endmodule : smf_regmap

// [shared/smf_consts.svh]
// offsets, field positions, reset values and timing counts of the stack monitor register map
`ifndef SMF_CONSTS_SVH
`define SMF_CONSTS_SVH
// register indices: flag, temperature, check and config bytes in read order
`define SMF_IDX_FLAGS_0 4'h0
`define SMF_IDX_FLAGS_1 4'h1
`define SMF_IDX_FLAGS_2 4'h2
`define SMF_IDX_TEMP_0 4'h3
`define SMF_IDX_TEMP_1 4'h4
`define SMF_IDX_TEMP_2 4'h5
`define SMF_IDX_TEMP_3 4'h6
`define SMF_IDX_TEMP_4 4'h7
`define SMF_IDX_CHECK 4'h8
`define SMF_IDX_CFG0 4'h9
// config_byte_zero field positions
`define SMF_CDC_LSB 0
`define SMF_CDC_MSB 2
`define SMF_TEN_CELL_BIT 3
`define SMF_POLL_BIT 4
`define SMF_PIN_ONE_BIT 5
`define SMF_PIN_TWO_BIT 6
// temperature_status_rev field positions
`define SMF_THERMAL_SHUTDOWN_SEEN_BIT 4
`define SMF_REV_LSB 5
// reset values and the forced duty code
`define SMF_CDC_RESET 3'h0
`define SMF_CDC_FORCED 3'h5
`define SMF_TEN_CELL_RESET 1'h0
`define SMF_POLL_RESET 1'h0
`define SMF_PIN_RESET 1'h1
// cycle counts of 1 ms at 125 MHz
`define SMF_CLK_MHZ 125
`define SMF_MS_CYCLES (`SMF_CLK_MHZ * 1000)
`endif

// [shared/smf_pkg.sv]
// types of the stack monitor register map
package smf_pkg;
  typedef enum logic [2:0] {
    smf_cdc_standby, smf_cdc_off, smf_cdc_13, smf_cdc_130,
    smf_cdc_500, smf_cdc_130_pd, smf_cdc_500_pd, smf_cdc_2000_pd
  } smf_cdc_t;
  typedef struct packed {
    logic [11:0] volts;
  } smf_cell_t;
  typedef struct packed {
    logic [11:0] ext_one;
    logic [11:0] ext_two;
    logic [11:0] internal;
  } smf_temp_t;
  typedef struct packed {
    logic vref_on;
    logic comparator_on;
  } smf_power_t;
endpackage : smf_pkg

// [verif/smf_host_model.sv]
// host-side model that issues register strobes to the stack monitor map
`timescale 1ns/100ps
module smf_host_model (
  // clock
  input wire logic clk,
  // register strobes
  output logic [3:0] reg_idx,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd,
  output logic temp_group_done,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_idx = 4'h0;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
    temp_group_done = 1'b0;
  end
  // ==========================================
  // strobes change on the falling edge only
  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    @(negedge clk);
    reg_idx = idx;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_wdata = ~d; // released data must not keep its last value
  endtask : wr
  task automatic rd(input logic [3:0] idx, output logic [7:0] d);
    @(negedge clk);
    reg_idx = idx;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask : rd
  // group read ends with the done pulse
  task automatic group_done();
    @(negedge clk);
    temp_group_done = 1'b1;
    @(negedge clk);
    temp_group_done = 1'b0;
  endtask : group_done
endmodule : smf_host_model

// [verif/testbench.sv]
// self-checking bench of the stack monitor register map
`timescale 1ns/100ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin err_total++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module testbench;
  import smf_pkg::*;
  logic clk, rst_n, shutdown_event, mm_n, pd_one, pd_two, ten, poll, tick, wr, rd, tgd;
  logic [3:0] idx;
  logic [7:0] wdata, rdata, chk, rv, crc;
  smf_cell_t [11:0] cv;
  smf_temp_t temps;
  smf_cdc_t code;
  smf_power_t pwr;
  int err_total = 0;
  int check_count = 0;
  smf_host_model host_u (.clk(clk), .reg_idx(idx), .reg_wr(wr), .reg_wdata(wdata),
    .reg_rd(rd), .temp_group_done(tgd), .reg_rdata(rdata));
  // pins have external pull-ups, so the level is low only while pulled down
  smf_regmap #(.MS_CYCLES(4)) dut_u (.clk(clk), .rst_n(rst_n), .reg_idx(idx), .reg_wr(wr),
    .reg_wdata(wdata), .reg_rd(rd), .temp_group_done(tgd), .reg_rdata(rdata),
    .packet_check_byte(chk), .cell_volts(cv), .temps(temps), .under_threshold(8'h10),
    .over_threshold(8'h20), .cell_mask(12'h000), .shutdown_event(shutdown_event),
    .measure_mode_pin_n(mm_n), .general_pin_one_in(~pd_one), .general_pin_two_in(~pd_two),
    .general_pin_one_pd(pd_one), .general_pin_two_pd(pd_two), .comparator_duty_code(code),
    .power_state(pwr), .ten_cell_select(ten), .poll_style_select(poll), .compare_tick(tick));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  function automatic logic [7:0] crc8(logic [7:0] c, logic [7:0] b);
    c = c ^ b;
    repeat (8) c = c[7] ? ((c << 1) ^ 8'h07) : (c << 1);
    return c;
  endfunction : crc8
  task automatic stop_test();
    if (err_total == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test
  // ==========================================
  task automatic t_reset();
    host_u.rd(4'h9, rv);
    `CHK("cfg reset", 8'h60, rv)
    `CHK("pulls off", 2'b00, {pd_one, pd_two})
    `CHK("standby", 2'b00, pwr)
  endtask : t_reset
  task automatic t_codes();
    for (int c = 0; c < 8; c++) begin
      host_u.wr(4'h9, {5'b01100, c[2:0]});
      `CHK("duty code", c[2:0], code)
      `CHK("comparator on", c > 1, pwr.comparator_on)
      `CHK("vref on", (c >= 1) && (c <= 4), pwr.vref_on)
    end
    mm_n = 1'b0;
    repeat (3) @(negedge clk);
    host_u.rd(4'h9, rv);
    `CHK("forced code", 3'h5, rv[2:0])
    `CHK("forced out", 3'h5, code)
    mm_n = 1'b1;
    repeat (3) @(negedge clk);
  endtask : t_codes
  task automatic t_pins();
    host_u.wr(4'h9, 8'h1a);
    repeat (3) @(negedge clk);
    `CHK("pulls on", 2'b11, {pd_one, pd_two})
    host_u.rd(4'h9, rv);
    `CHK("cfg pins", 8'h1a, rv)
    `CHK("modes", 2'b11, {ten, poll})
  endtask : t_pins
  task automatic t_flags(input logic tm);
    int n;
    host_u.wr(4'h9, {4'b0110, tm, 3'h2});
    n = 0;
    while (n < 2) begin
      @(negedge clk);
      if (tick === 1'b1) n = n + 1;
      if ($time > 200000) begin
        err_total++;
        stop_test();
      end
    end
    host_u.rd(4'h8, rv);
    crc = 8'h41;
    for (int b = 0; b < 3; b++) begin
      host_u.rd(b[3:0], rv);
      crc = crc8(crc, rv);
      `CHK("flags", (tm && b == 2) ? 8'h09 : 8'h99, rv)
    end
    host_u.rd(4'h8, rv);
    `CHK("check byte", crc, rv)
  endtask : t_flags
  task automatic t_temps();
    @(negedge clk);
    shutdown_event = 1'b1;
    @(negedge clk);
    shutdown_event = 1'b0;
    host_u.wr(4'h3, 8'hff);
    for (int b = 0; b < 5; b++) begin
      host_u.rd(4'h3 + b[3:0], rv);
      case (b)
        0: `CHK("temp0", 8'hbc, rv)
        1: `CHK("temp1", 8'h3a, rv)
        2: `CHK("temp2", 8'h12, rv)
        3: `CHK("temp3", 8'h56, rv)
        default: `CHK("temp4", 8'h34, rv)
      endcase
    end
    host_u.group_done();
    host_u.rd(4'h7, rv);
    `CHK("shutdown clear", 8'h24, rv)
    host_u.rd(4'hf, rv);
    `CHK("unmapped", 8'h00, rv)
  endtask : t_temps
  initial begin
    rst_n = 1'b0;
    mm_n = 1'b1;
    shutdown_event = 1'b0;
    temps = '{ext_one: 12'habc, ext_two: 12'h123, internal: 12'h456};
    for (int c = 0; c < 12; c++) cv[c].volts = c[0] ? 12'h300 : 12'h050;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_codes();
    t_pins();
    t_flags(1'b1);
    t_flags(1'b0);
    t_temps();
    stop_test();
  end
endmodule : testbench
